// ---- logic/ppfs_pkg.sv ----
// constants, field layouts and carrier types of the port power and fault status bank
// How it works
// - debug accessory detect pin sets power status bit 7, follows the pin
// - init in progress bit 6 is never set, always reads zero
// - bit 5 shows sourcing above vSafe5V, monitor only
// - bit 4 shows sourcing enabled, monitor only
// - bit 3 shows supply detection active, zero after reset
// - bit 2 sets above 4 V while detection is active, clears below 3.5 V or with detection off, holds between
// - present falling, zero threshold, auto enabled starts discharge to vSafe0V
// - bit 1 shows cable power present on either line above 2.4 V
// - bit 0 shows sinking the supply to the load
// - fault bit 7 reads zero, reader ignores it
// - forced off fault bit 6 stays zero
// - auto discharge not reaching vSafe0V within tSafe0V latches fault bit 5
// - forced discharge not reaching vSafe0V within tSafe0V latches fault bit 4
// - supply overcurrent and overvoltage bits 3 and 2 stay zero
// - cable power overcurrent or drop with switch closed latches bit 1
// - transmit with empty buffer latches fault bit 0
// - fault register at 0x1f, resets to 0x00
// - power status at 0x1e, resets to 0x00, read only
package ppfs_pkg;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [7:0] PPFS_IDX_POWER   = 8'h1e;
  localparam logic [7:0] PPFS_IDX_FAULT   = 8'h1f;
  localparam logic [7:0] PPFS_IDX_CTRL    = 8'h20;
  localparam logic [7:0] PPFS_RESET_VALUE = 8'h00;

  // ==========================================================
  // fault bit positions
  localparam int PPFS_F_RSVD      = 7;
  localparam int PPFS_F_FORCE_OFF = 6;
  localparam int PPFS_F_AUTO_DIS  = 5;
  localparam int PPFS_F_FORCE_DIS = 4;
  localparam int PPFS_F_OCP       = 3;
  localparam int PPFS_F_OVP       = 2;
  localparam int PPFS_F_CABLE_OCP = 1;
  localparam int PPFS_F_IF_ERR    = 0;

  // control bit positions
  localparam int PPFS_C_AUTO_EN   = 0;
  localparam int PPFS_C_FORCE_CMD = 1;

  // ==========================================================
  // timing
  localparam int PPFS_CLK_HZ      = 50_000_000;
  localparam int PPFS_T_SAFE0V_MS = 100;

  // ==========================================================
  // power status layout, msb first
  typedef struct packed {
    logic debug_accessory_attached_flag;
    logic init_in_progress_flag;
    logic sourcing_high_flag;
    logic sourcing_flag;
    logic supply_detect_on_flag;
    logic supply_present_flag;
    logic cable_power_present_flag;
    logic sinking_flag;
  } ppfs_power_t;

  // asynchronous analog and pin levels
  typedef struct packed {
    logic supply_above_4v;
    logic supply_above_3v5;
    logic supply_below_safe0v;
    logic cable_power_above_2v4;
    logic cable_power_overcurrent;
    logic debug_accessory_detect;
  } ppfs_pins_t;

  // same clock status from the port logic
  typedef struct packed {
    logic sourcing;
    logic sourcing_high;
    logic detect_on;
    logic sinking;
    logic cable_switch_closed;
    logic sink_threshold_zero;
  } ppfs_state_t;

  // discharge sequencer, gray along idle-auto-forced
  typedef enum logic [1:0] {
    PPFS_DIS_IDLE   = 2'b00,
    PPFS_DIS_AUTO   = 2'b01,
    PPFS_DIS_FORCED = 2'b11
  } ppfs_dis_t;

endpackage

// ---- logic/ppfs_top.sv ----
// port power status, fault status and discharge supervision behind an avalon-mm slave
`timescale 1ns/1ps
`default_nettype none
module ppfs_top
#(
  parameter int T_SAFE0V_CYCLES = (ppfs_pkg::PPFS_CLK_HZ / 1000) * ppfs_pkg::PPFS_T_SAFE0V_MS
)
(
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  // avalon-mm slave
  input  wire logic [9:0]            avs_address_in,
  input  wire logic                  avs_read_in,
  input  wire logic                  avs_write_in,
  input  wire logic [31:0]           avs_writedata_in,
  input  wire logic [3:0]            avs_byteenable_in,
  output logic      [31:0]           avs_readdata_out,
  output logic                       avs_waitrequest_out,
  // pins and comparators
  input  wire ppfs_pkg::ppfs_pins_t  pins_in,
  // port logic status and events
  input  wire ppfs_pkg::ppfs_state_t state_in,
  input  wire logic                  transmit_cmd_in,
  input  wire logic                  tx_buffer_empty_in,
  // discharge path and status view
  output logic                       discharge_on_out,
  output ppfs_pkg::ppfs_power_t      power_flags_out
);
  import ppfs_pkg::*;

  localparam int TMR_W = 32;
  localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(T_SAFE0V_CYCLES - 1);

  // ==========================================================
  // pin synchronisers
  ppfs_pins_t pins_meta_reg;
  ppfs_pins_t pins_reg;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pins_meta_reg <= '0;
      pins_reg      <= '0;
    end
    else
    begin
      pins_meta_reg <= pins_in;
      pins_reg      <= pins_meta_reg;
    end
  end

  // ==========================================================
  // power status
  ppfs_power_t power_reg;
  logic        present_reg;
  logic        present_next;
  logic        cable_prev_reg;

  always_comb
  begin
    present_next = present_reg;
    if (!state_in.detect_on)
      present_next = 1'b0;
    else if (pins_reg.supply_above_4v)
      present_next = 1'b1;
    else if (!pins_reg.supply_above_3v5)
      present_next = 1'b0;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      present_reg <= 1'b0;
    else
      present_reg <= present_next;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      power_reg <= ppfs_power_t'(PPFS_RESET_VALUE);
    else
    begin
      power_reg.debug_accessory_attached_flag <= pins_reg.debug_accessory_detect;
      power_reg.init_in_progress_flag         <= 1'b0;
      power_reg.sourcing_high_flag            <= state_in.sourcing_high;
      power_reg.sourcing_flag                 <= state_in.sourcing;
      power_reg.supply_detect_on_flag         <= state_in.detect_on;
      power_reg.supply_present_flag           <= present_next;
      power_reg.cable_power_present_flag      <= pins_reg.cable_power_above_2v4;
      power_reg.sinking_flag                  <= state_in.sinking;
    end
  end

  assign power_flags_out = power_reg;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cable_prev_reg <= 1'b0;
    else
      cable_prev_reg <= pins_reg.cable_power_above_2v4;
  end

  // ==========================================================
  // avalon-mm slave, one wait cycle per access
  logic        req;
  logic        accept;
  logic [7:0]  index;
  logic        wr_fault;
  logic        wr_ctrl;
  logic [7:0]  ctrl_reg;
  logic [7:0]  fault_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;

  assign req      = avs_read_in | avs_write_in;
  assign index    = avs_address_in[9:2];
  assign accept   = req & wait_reg;
  assign wr_fault = avs_write_in & !wait_reg & avs_byteenable_in[0] & (index == PPFS_IDX_FAULT);
  assign wr_ctrl  = avs_write_in & !wait_reg & avs_byteenable_in[0] & (index == PPFS_IDX_CTRL);

  function automatic logic [31:0] read_mux(input logic [7:0] idx);
    logic [31:0] v;
    v = '0;
    case (idx)
      PPFS_IDX_POWER: v[7:0] = power_reg;
      PPFS_IDX_FAULT: v[7:0] = fault_reg;
      PPFS_IDX_CTRL:  v[7:0] = ctrl_reg;
      default:        v = '0;
    endcase
    return v;
  endfunction

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      wait_reg <= 1'b1;
    else
      wait_reg <= !accept;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rdata_reg <= '0;
    else if (accept)
      rdata_reg <= avs_read_in ? read_mux(index) : '0;
  end

  assign avs_waitrequest_out = wait_reg;
  assign avs_readdata_out    = rdata_reg;

  // ==========================================================
  // discharge sequencer
  ppfs_dis_t        dis_reg;
  logic [TMR_W-1:0] tmr_reg;
  logic             auto_start;
  logic             timed_out;
  logic             dis_on_reg;

  assign auto_start = present_reg & !present_next & state_in.sink_threshold_zero
                    & ctrl_reg[PPFS_C_AUTO_EN];
  assign timed_out  = (tmr_reg == TMR_LAST);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      dis_reg <= PPFS_DIS_IDLE;
    else
    begin
      case (dis_reg)
        PPFS_DIS_IDLE:
        begin
          if (ctrl_reg[PPFS_C_FORCE_CMD])
            dis_reg <= PPFS_DIS_FORCED;
          else if (auto_start)
            dis_reg <= PPFS_DIS_AUTO;
        end
        PPFS_DIS_AUTO, PPFS_DIS_FORCED:
        begin
          if (pins_reg.supply_below_safe0v || timed_out)
            dis_reg <= PPFS_DIS_IDLE;
        end
        default: dis_reg <= PPFS_DIS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      tmr_reg <= '0;
    else if (dis_reg == PPFS_DIS_IDLE)
      tmr_reg <= '0;
    else if (!timed_out)
      tmr_reg <= tmr_reg + TMR_W'(1);
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      dis_on_reg <= 1'b0;
    else
      dis_on_reg <= (dis_reg != PPFS_DIS_IDLE) && !pins_reg.supply_below_safe0v && !timed_out;
  end

  assign discharge_on_out = dis_on_reg;

  // ==========================================================
  // control register, forced command self clears at end
  logic force_end;

  assign force_end = (dis_reg == PPFS_DIS_FORCED) && (pins_reg.supply_below_safe0v || timed_out);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ctrl_reg <= PPFS_RESET_VALUE;
    else
    begin
      if (wr_ctrl)
      begin
        ctrl_reg[PPFS_C_AUTO_EN]   <= avs_writedata_in[PPFS_C_AUTO_EN];
        ctrl_reg[PPFS_C_FORCE_CMD] <= avs_writedata_in[PPFS_C_FORCE_CMD];
      end
      if (force_end)
        ctrl_reg[PPFS_C_FORCE_CMD] <= 1'b0;
    end
  end

  // ==========================================================
  // fault latches, set beats write-one clear
  logic [7:0] fault_set;
  logic [7:0] fault_clr;

  always_comb
  begin
    fault_set = '0;
    fault_set[PPFS_F_AUTO_DIS]  = (dis_reg == PPFS_DIS_AUTO) && timed_out
                                && !pins_reg.supply_below_safe0v;
    fault_set[PPFS_F_FORCE_DIS] = (dis_reg == PPFS_DIS_FORCED) && timed_out
                                && !pins_reg.supply_below_safe0v;
    fault_set[PPFS_F_CABLE_OCP] = pins_reg.cable_power_overcurrent
                                | (cable_prev_reg & !pins_reg.cable_power_above_2v4
                                   & state_in.cable_switch_closed);
    fault_set[PPFS_F_IF_ERR]    = transmit_cmd_in & tx_buffer_empty_in;
    fault_clr = wr_fault ? avs_writedata_in[7:0] : '0;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      fault_reg <= PPFS_RESET_VALUE;
    else
    begin
      fault_reg <= (fault_reg & ~fault_clr) | fault_set;
      fault_reg[PPFS_F_RSVD]      <= 1'b0;
      fault_reg[PPFS_F_FORCE_OFF] <= 1'b0;
      fault_reg[PPFS_F_OCP]       <= 1'b0;
      fault_reg[PPFS_F_OVP]       <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- tb/ppfs_asserts.sv ----
// concurrent checks on the status bank ports
`timescale 1ns/1ps
`default_nettype none
module ppfs_asserts
(
  // clock and reset
  input wire logic                  clk_in,
  input wire logic                  rst_b_in,
  // register bus
  input wire logic [9:0]            avs_address_in,
  input wire logic                  avs_read_in,
  input wire logic [31:0]           avs_readdata_out,
  input wire logic                  avs_waitrequest_out,
  // port side
  input wire ppfs_pkg::ppfs_pins_t  pins_in,
  input wire ppfs_pkg::ppfs_state_t state_in,
  input wire logic                  discharge_on_out,
  input wire ppfs_pkg::ppfs_power_t power_flags_out
);
  import ppfs_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // ==========================================================
  // power status
  chk_init_zero:
    assert property (!power_flags_out.init_in_progress_flag) else $error("init flag set");
  chk_state_track:
    assert property ($past(rst_b_in) |-> {power_flags_out[5:3], power_flags_out[0]} == $past({state_in.sourcing_high,
      state_in.sourcing, state_in.detect_on, state_in.sinking})) else $error("state flags wrong");
  chk_present_set:
    assert property ((state_in.detect_on && pins_in.supply_above_4v) [*4] |-> power_flags_out.supply_present_flag)
      else $error("present not set");
  chk_present_clr:
    assert property (!pins_in.supply_above_3v5 [*4] |-> !power_flags_out.supply_present_flag)
      else $error("present not cleared");
  chk_debug_follow:
    assert property ($stable(pins_in.debug_accessory_detect) [*4] |-> power_flags_out.debug_accessory_attached_flag
      == pins_in.debug_accessory_detect) else $error("debug flag wrong");
  chk_cable_follow:
    assert property ($stable(pins_in.cable_power_above_2v4) [*4] |-> power_flags_out.cable_power_present_flag
      == pins_in.cable_power_above_2v4) else $error("cable flag wrong");
  // ==========================================================
  // fault reads and discharge
  chk_fault_fixed:
    assert property (!avs_waitrequest_out && avs_read_in && avs_address_in[9:2] == PPFS_IDX_FAULT |->
      avs_readdata_out[7:6] == 2'b00 && avs_readdata_out[3:2] == 2'b00) else $error("fixed fault bits set");
  chk_dis_bound:
    assert property ($rose(discharge_on_out) |-> ##[1:200] !discharge_on_out) else $error("discharge never ends");
  chk_dis_stop:
    assert property ((discharge_on_out && pins_in.supply_below_safe0v) [*3] |-> ##[1:3] !discharge_on_out)
      else $error("discharge not stopped");
  cov_dis: cover property ($rose(discharge_on_out));
  cov_present_fall: cover property ($fell(power_flags_out.supply_present_flag));
  cov_fault_read: cover property (!avs_waitrequest_out && avs_read_in && avs_address_in[9:2] == PPFS_IDX_FAULT);
endmodule
`default_nettype wire

// ---- tb/ppfs_pm_model.sv ----
// port manager model: avalon-mm master cycles
`timescale 1ns/1ps
`default_nettype none
module ppfs_pm_model
#(
  parameter int POLL_CYCLES = 50
)
(
  // clock
  input  wire logic        clk_in,
  // avalon-mm master
  output var logic [9:0]   adr_out,
  output var logic         rd_out,
  output var logic         wr_out,
  output var logic [31:0]  wd_out,
  output var logic [3:0]   be_out,
  input  wire logic [31:0] rdat_in,
  input  wire logic        wait_in
);
  import ppfs_pkg::*;
  initial
  begin
    adr_out = 10'h000;
    rd_out = 1'b0;
    wr_out = 1'b0;
    wd_out = 32'h00000000;
    be_out = 4'h1;
  end
  // one access with chosen byte enables, held until waitrequest low
  task automatic acc_be(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] b,
                        output logic [7:0] q);
    @(posedge clk_in);
    adr_out <= {idx, 2'b00};
    rd_out <= !w;
    wr_out <= w;
    wd_out <= {24'h000000, d};
    be_out <= b;
    do @(posedge clk_in); while (wait_in !== 1'b0);
    q = rdat_in[7:0];
    rd_out <= 1'b0;
    wr_out <= 1'b0;
    adr_out <= ~{idx, 2'b00};
    wd_out <= ~{24'h000000, d};
    be_out <= ~b;
  endtask
  // one access on the low byte lane
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [7:0] q);
    acc_be(w, idx, d, 4'h1, q);
  endtask
  // polling period after enabling detection
  task automatic settle();
    repeat (POLL_CYCLES) @(posedge clk_in);
  endtask
  task automatic clr(input logic [7:0] m);
    logic [7:0] q;
    acc(1'b1, PPFS_IDX_FAULT, m, q);
  endtask
endmodule
`default_nettype wire

// ---- tb/port_power_fault_status_bench.sv ----
// self-checking bench of the port power and fault status bank
`timescale 1ns/1ps
`default_nettype none
module port_power_fault_status_bench;
  import ppfs_pkg::*;
  logic        clk_in;
  logic        rst_b_in;
  logic [9:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        waitr;
  ppfs_pins_t  pins;
  ppfs_state_t st;
  logic        tx_cmd;
  logic        tx_empty;
  logic        dis_on;
  ppfs_power_t pwr;
  int          mismatches;
  int          check_count;
  logic [7:0]  q;
  ppfs_top #(.T_SAFE0V_CYCLES(20)) i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdat),
    .avs_waitrequest_out(waitr), .pins_in(pins), .state_in(st), .transmit_cmd_in(tx_cmd),
    .tx_buffer_empty_in(tx_empty), .discharge_on_out(dis_on), .power_flags_out(pwr));
  ppfs_pm_model i_pm (.clk_in(clk_in), .adr_out(adr), .rd_out(rd), .wr_out(wr), .wd_out(wd), .be_out(be),
    .rdat_in(rdat), .wait_in(waitr));
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic check(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    i_pm.acc(1'b0, idx, 8'h00, q);
    check(q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic wait_dis(input logic v);
    int n;
    n = 0;
    while (dis_on !== v && n < 50)
    begin
      @(posedge clk_in);
      n++;
    end
    check({7'h00, dis_on}, {7'h00, v});
  endtask
  task automatic tx_pulse(input logic e);
    @(posedge clk_in);
    tx_cmd <= 1'b1;
    tx_empty <= e;
    @(posedge clk_in);
    tx_cmd <= 1'b0;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rd_chk(PPFS_IDX_POWER, 8'h00);
    rd_chk(PPFS_IDX_FAULT, 8'h00);
    i_pm.acc(1'b1, 8'h21, 8'hff, q);
    rd_chk(8'h21, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_status();
    st <= 6'b111100;
    pins <= 6'b110101;
    i_pm.settle();
    rd_chk(PPFS_IDX_POWER, 8'hbf);
    i_pm.acc(1'b1, PPFS_IDX_POWER, 8'h00, q);
    rd_chk(PPFS_IDX_POWER, 8'hbf);
    pins <= 6'b010101;
    cyc(5);
    check(pwr, 8'hbf);
    pins <= 6'b000000;
    st <= 6'b000000;
    cyc(5);
    check(pwr, 8'h00);
    $display("test status done");
  endtask
  task automatic t_tx();
    tx_pulse(1'b0);
    rd_chk(PPFS_IDX_FAULT, 8'h00);
    tx_pulse(1'b1);
    rd_chk(PPFS_IDX_FAULT, 8'h01);
    i_pm.acc(1'b1, PPFS_IDX_FAULT, 8'h00, q);
    rd_chk(PPFS_IDX_FAULT, 8'h01);
    i_pm.acc_be(1'b1, PPFS_IDX_FAULT, 8'hff, 4'he, q);
    rd_chk(PPFS_IDX_FAULT, 8'h01);
    i_pm.clr(8'hff);
    rd_chk(PPFS_IDX_FAULT, 8'h00);
    $display("test transmit done");
  endtask
  task automatic t_cable();
    st <= 6'b000010;
    pins <= 6'b000100;
    cyc(5);
    rd_chk(PPFS_IDX_FAULT, 8'h00);
    pins <= 6'b000000;
    cyc(5);
    rd_chk(PPFS_IDX_FAULT, 8'h02);
    i_pm.clr(8'h02);
    pins <= 6'b000010;
    cyc(5);
    pins <= 6'b000000;
    rd_chk(PPFS_IDX_FAULT, 8'h02);
    st <= 6'b000000;
    i_pm.clr(8'h02);
    $display("test cable done");
  endtask
  task automatic t_dis();
    i_pm.acc(1'b1, PPFS_IDX_CTRL, 8'h01, q);
    st <= 6'b001001;
    pins <= 6'b110000;
    cyc(6);
    pins <= 6'b000000;
    wait_dis(1'b1);
    wait_dis(1'b0);
    rd_chk(PPFS_IDX_FAULT, 8'h20);
    i_pm.clr(8'hff);
    i_pm.acc(1'b1, PPFS_IDX_CTRL, 8'h02, q);
    wait_dis(1'b1);
    wait_dis(1'b0);
    rd_chk(PPFS_IDX_FAULT, 8'h10);
    i_pm.clr(8'hff);
    i_pm.acc(1'b1, PPFS_IDX_CTRL, 8'h02, q);
    wait_dis(1'b1);
    pins <= 6'b001000;
    wait_dis(1'b0);
    rd_chk(PPFS_IDX_FAULT, 8'h00);
    $display("test discharge done");
  endtask
  task automatic t_reset();
    pins <= 6'b000000;
    st <= 6'b000000;
    tx_pulse(1'b1);
    rd_chk(PPFS_IDX_FAULT, 8'h01);
    rst_b_in <= 1'b0;
    cyc(8);
    rst_b_in <= 1'b1;
    rd_chk(PPFS_IDX_FAULT, 8'h00);
    check(pwr, 8'h00);
    $display("test reset done");
  endtask
  initial
  begin
    rst_b_in = 1'b0;
    pins = 6'b000000;
    st = 6'b000000;
    tx_cmd = 1'b0;
    tx_empty = 1'b0;
    mismatches = 0;
    check_count = 0;
    cyc(8);
    rst_b_in <= 1'b1;
    t_regs();
    t_status();
    t_tx();
    t_cable();
    t_dis();
    t_reset();
    wrap_up();
  end
  initial
  begin
    #100us;
    mismatches++;
    wrap_up();
  end
endmodule
bind ppfs_top ppfs_asserts i_chk (.clk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_readdata_out,
  .avs_waitrequest_out, .pins_in, .state_in, .discharge_on_out, .power_flags_out);
`default_nettype wire
